// *** rtl/hdc_dma_ctrl.sv ***
/*
  holds the dma request control: configuration registers, request pin
  sequencing for four transfer modes, terminal count and retrigger logic.
  assumes pins come from outside the clock domain, ack is active high, and
  the buffer ram side feeds words through the fifo toward the host.
*/
// How it works
// - wide_access_enable selects 16-bit host data, else 8-bit.
// - non-burst/burst end on external tc, or internal tc too when enabled.
// - external retrigger: request returns after refresh_event_in falls.
// - internal retrigger: request returns when the gate timer expires.
// - terminal count is count_msb plus count_low_bits, ignored when disabled.
// - external retrigger start: immediate, or after refresh when sync start set.
// - gate time at least 350 ns, or 750 ns when selected.
// - transfer_mode_sel picks non-burst, burst, timer burst or cycle burst.
// - count_end_polarity set makes the terminal count pin active low.
// - request_polarity set drives the request pin active low.
// - terminal count covers 1 to 512, zero means 512.
// - timer burst lasts burst_time_term steps of 100 ns, zero means maximum.
// - cycle burst lasts 2 to 256 transfers, zero means 256; 1 is illegal.
`timescale 1ns/10ps
module hdc_dma_ctrl #(
  parameter int FIFO_DEPTH = hdc_pkg::FIFO_DEPTH,
  parameter int STEP_CYCLES = hdc_pkg::STEP_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [hdc_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [hdc_pkg::DATA_W-1:0] buf_data,
  input wire logic buf_valid,
  output logic buf_ready,
  output logic dma_req_pin,
  input wire logic dma_ack_pin,
  input wire logic count_end_pin,
  input wire logic refresh_event_in,
  output logic [hdc_pkg::DATA_W-1:0] host_data,
  output logic host_wide
);

  // ********************************
  // registers and fields
  // ********************************
  logic [7:0] bus_dma_control_r;
  logic [7:0] dma_term_count_r;
  logic [7:0] rdata_r;
  logic done_r;
  logic wide_access_enable;
  logic itc_retrigger_select;
  logic msb_refresh_sync_start_gate_time_select;
  hdc_pkg::hdc_mode_t transfer_mode_sel;
  logic count_end_polarity;
  logic request_polarity;
  logic wr_ctrl;
  logic wr_term;
  logic wr_run;
  logic start_req;
  logic abort_req;
  logic done_clear;

  assign wide_access_enable = bus_dma_control_r[hdc_pkg::BIT_WIDE];
  assign itc_retrigger_select = bus_dma_control_r[hdc_pkg::BIT_ITC_RETRIGGER_SELECT];
  assign msb_refresh_sync_start_gate_time_select = bus_dma_control_r[hdc_pkg::BIT_MSB_REFRESH_SYNC_START_GATE_TIME_SELECT];
  assign transfer_mode_sel = hdc_pkg::hdc_mode_t'(bus_dma_control_r[hdc_pkg::BIT_MODE_HI:hdc_pkg::BIT_MODE_LO]);
  assign count_end_polarity = bus_dma_control_r[hdc_pkg::BIT_TC_POL];
  assign request_polarity = bus_dma_control_r[hdc_pkg::BIT_REQ_POL];

  assign wr_ctrl = reg_write & (reg_addr == hdc_pkg::OFS_BUS_DMA_CONTROL);
  assign wr_term = reg_write & (reg_addr == hdc_pkg::OFS_DMA_TERM_COUNT);
  assign wr_run = reg_write & (reg_addr == hdc_pkg::OFS_DMA_RUN);
  assign start_req = wr_run & reg_wdata[hdc_pkg::BIT_RUN_START];
  assign abort_req = wr_run & reg_wdata[hdc_pkg::BIT_RUN_ABORT];
  assign done_clear = wr_run & reg_wdata[hdc_pkg::BIT_RUN_DONE];

  // ********************************
  // pin synchronisers
  // ********************************
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_s3_r;
  logic tc_s1_r;
  logic tc_s2_r;
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_s3_r;
  logic ack_rise;
  logic ref_fall;
  logic ext_tc;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
      tc_s1_r <= 1'b0;
      tc_s2_r <= 1'b0;
      ref_s1_r <= 1'b1;
      ref_s2_r <= 1'b1;
      ref_s3_r <= 1'b1;
    end else begin
      ack_s1_r <= dma_ack_pin;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      tc_s1_r <= count_end_pin;
      tc_s2_r <= tc_s1_r;
      ref_s1_r <= refresh_event_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  assign ack_rise = ack_s2_r & ~ack_s3_r;
  assign ref_fall = ref_s3_r & ~ref_s2_r;
  assign ext_tc = tc_s2_r ^ count_end_polarity;

  // ********************************
  // data fifo
  // ********************************
  logic [hdc_pkg::DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic xfer;

  hdc_fifo #(
    .WIDTH(hdc_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_data(buf_data),
    .in_valid(buf_valid),
    .in_ready(buf_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(xfer)
  );

  // ********************************
  // sequencer
  // ********************************
  hdc_pkg::hdc_state_t state_r;
  hdc_pkg::hdc_state_t state_nxt;
  logic prog_mode;
  logic ext_retrig;
  logic hold_r;
  logic [8:0] xfer_cnt_r;
  logic [7:0] burst_cnt_r;
  logic [7:0] step_cnt_r;
  logic [7:0] gate_cnt_r;
  logic [7:0] prescale_r;
  logic step_tick;
  logic int_tc_hit;
  logic end_xfer;
  logic burst_over;
  logic gate_over;
  logic [7:0] gate_limit;

  assign prog_mode = transfer_mode_sel[1];
  assign ext_retrig = prog_mode & ~itc_retrigger_select;
  assign xfer = (state_r == hdc_pkg::ST_ACTIVE) & fifo_valid & ack_rise;
  assign step_tick = (prescale_r == 8'(STEP_CYCLES - 1));

  // wraps through zero so a zero setting means 512
  assign int_tc_hit = xfer & ~prog_mode & itc_retrigger_select &
                      ((xfer_cnt_r + 9'h001) == {msb_refresh_sync_start_gate_time_select, dma_term_count_r});
  assign end_xfer = int_tc_hit | (ack_s2_r & ext_tc & (state_r != hdc_pkg::ST_IDLE));

  assign gate_limit = msb_refresh_sync_start_gate_time_select ? 8'(hdc_pkg::GATE_LONG_CYCLES - 1)
                                    : 8'(hdc_pkg::GATE_SHORT_CYCLES - 1);
  assign gate_over = itc_retrigger_select ? (gate_cnt_r == gate_limit) : ref_fall;

  always_comb begin
    burst_over = 1'b0;
    case (transfer_mode_sel)
      hdc_pkg::MODE_PB_TIMER: begin
        burst_over = step_tick & ((step_cnt_r + 8'h01) == dma_term_count_r);
      end
      hdc_pkg::MODE_PB_CYCLE: begin
        burst_over = xfer & ((burst_cnt_r + 8'h01) == dma_term_count_r);
      end
      default: begin
        burst_over = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hdc_pkg::ST_IDLE: begin
        if (start_req) begin
          state_nxt = (ext_retrig & msb_refresh_sync_start_gate_time_select) ? hdc_pkg::ST_WAIT_SYNC : hdc_pkg::ST_ACTIVE;
        end
      end
      hdc_pkg::ST_WAIT_SYNC: begin
        if (ref_fall) begin
          state_nxt = hdc_pkg::ST_ACTIVE;
        end
      end
      hdc_pkg::ST_ACTIVE: begin
        if (burst_over) begin
          state_nxt = hdc_pkg::ST_GATE;
        end
      end
      hdc_pkg::ST_GATE: begin
        if (gate_over) begin
          state_nxt = hdc_pkg::ST_ACTIVE;
        end
      end
      default: begin
        state_nxt = hdc_pkg::ST_IDLE;
      end
    endcase
    if (end_xfer | abort_req) begin
      state_nxt = hdc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= hdc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // transfer tally for the internal terminal count
  always_ff @(posedge clock) begin
    if (rst) begin
      xfer_cnt_r <= 9'h000;
    end else if (start_req & (state_r == hdc_pkg::ST_IDLE)) begin
      xfer_cnt_r <= 9'h000;
    end else if (xfer) begin
      xfer_cnt_r <= xfer_cnt_r + 9'h001;
    end
  end

  // per-burst cycle count and time steps
  always_ff @(posedge clock) begin
    if (rst) begin
      burst_cnt_r <= 8'h00;
      step_cnt_r <= 8'h00;
      prescale_r <= 8'h00;
    end else if (state_r != hdc_pkg::ST_ACTIVE) begin
      burst_cnt_r <= 8'h00;
      step_cnt_r <= 8'h00;
      prescale_r <= 8'h00;
    end else begin
      if (xfer) begin
        burst_cnt_r <= burst_cnt_r + 8'h01;
      end
      if (step_tick) begin
        prescale_r <= 8'h00;
        step_cnt_r <= step_cnt_r + 8'h01;
      end else begin
        prescale_r <= prescale_r + 8'h01;
      end
    end
  end

  // gate timer for internal retrigger
  always_ff @(posedge clock) begin
    if (rst) begin
      gate_cnt_r <= 8'h00;
    end else if (state_r != hdc_pkg::ST_GATE) begin
      gate_cnt_r <= 8'h00;
    end else if (gate_cnt_r != gate_limit) begin
      gate_cnt_r <= gate_cnt_r + 8'h01;
    end
  end

  // non-burst drops the request after each transfer until ack releases
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (xfer & (transfer_mode_sel == hdc_pkg::MODE_NON_BURST)) begin
      hold_r <= 1'b1;
    end else if (~ack_s2_r) begin
      hold_r <= 1'b0;
    end
  end

  // ********************************
  // pins toward the host
  // ********************************
  logic req_active;
  logic req_pin_r;
  logic [hdc_pkg::DATA_W-1:0] host_data_r;

  assign req_active = (state_r == hdc_pkg::ST_ACTIVE) & (state_nxt == hdc_pkg::ST_ACTIVE) &
                      fifo_valid & ~hold_r & ~xfer;

  always_ff @(posedge clock) begin
    if (rst) begin
      req_pin_r <= 1'b0;
    end else begin
      req_pin_r <= req_active ^ request_polarity;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      host_data_r <= '0;
    end else if (xfer) begin
      host_data_r <= wide_access_enable ? fifo_data : {8'h00, fifo_data[7:0]};
    end
  end

  assign dma_req_pin = req_pin_r;
  assign host_data = host_data_r;
  assign host_wide = wide_access_enable;

  // ********************************
  // register port
  // ********************************
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_dma_control_r <= hdc_pkg::RST_BUS_DMA_CONTROL;
      dma_term_count_r <= hdc_pkg::RST_DMA_TERM_COUNT;
    end else begin
      if (wr_ctrl) begin
        bus_dma_control_r <= reg_wdata & ~(8'h01 << hdc_pkg::BIT_RESERVED);
      end
      if (wr_term) begin
        dma_term_count_r <= reg_wdata;
      end
    end
  end

  // end of transfer flag, a new end beats a clear
  always_ff @(posedge clock) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (end_xfer & (state_r != hdc_pkg::ST_IDLE)) begin
      done_r <= 1'b1;
    end else if (done_clear) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        hdc_pkg::OFS_BUS_DMA_CONTROL: rdata_r <= bus_dma_control_r;
        hdc_pkg::OFS_DMA_TERM_COUNT: rdata_r <= dma_term_count_r;
        hdc_pkg::OFS_DMA_RUN: rdata_r <= {state_r, 1'b0, 1'b0, done_r, (state_r != hdc_pkg::ST_IDLE)};
        hdc_pkg::OFS_XFER_COUNT: rdata_r <= xfer_cnt_r[7:0];
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : hdc_dma_ctrl

// *** inc/hdc_pkg.sv ***
/*
  holds the shared constants of the host dma request control block: register
  offsets, field positions, reset values, transfer modes, states and timing.
  assumes a single 250 MHz clock and an 8-bit register port.
*/
package hdc_pkg;

  // ********************************
  // register map
  // ********************************
  localparam int REG_ADDR_W = 2;
  localparam logic [1:0] OFS_BUS_DMA_CONTROL = 2'h0;
  localparam logic [1:0] OFS_DMA_TERM_COUNT = 2'h1;
  localparam logic [1:0] OFS_DMA_RUN = 2'h2;
  localparam logic [1:0] OFS_XFER_COUNT = 2'h3;
  localparam logic [7:0] RST_BUS_DMA_CONTROL = 8'h00;
  localparam logic [7:0] RST_DMA_TERM_COUNT = 8'h00;

  // ********************************
  // bus_dma_control fields
  // ********************************
  localparam int BIT_WIDE = 7;
  localparam int BIT_RESERVED = 6;
  localparam int BIT_ITC_RETRIGGER_SELECT = 5;
  localparam int BIT_MSB_REFRESH_SYNC_START_GATE_TIME_SELECT = 4;
  localparam int BIT_MODE_HI = 3;
  localparam int BIT_MODE_LO = 2;
  localparam int BIT_TC_POL = 1;
  localparam int BIT_REQ_POL = 0;

  // ********************************
  // run register fields
  // ********************************
  localparam int BIT_RUN_START = 0;
  localparam int BIT_RUN_DONE = 1;
  localparam int BIT_RUN_ABORT = 2;

  // ********************************
  // modes and states
  // ********************************
  typedef enum logic [1:0] {
    MODE_NON_BURST = 2'h0,
    MODE_BURST = 2'h1,
    MODE_PB_TIMER = 2'h2,
    MODE_PB_CYCLE = 2'h3
  } hdc_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT_SYNC = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_GATE = 4'h8
  } hdc_state_t;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_MHZ = 250;
  localparam int STEP_NS = 100;
  localparam int GATE_SHORT_NS = 350;
  localparam int GATE_LONG_NS = 750;
  localparam int STEP_CYCLES = (STEP_NS * CLK_MHZ) / 1000;
  localparam int GATE_SHORT_CYCLES = (GATE_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int GATE_LONG_CYCLES = (GATE_LONG_NS * CLK_MHZ + 999) / 1000;

  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;

endpackage : hdc_pkg

// *** rtl/hdc_fifo.sv ***
/*
  holds a synchronous fifo with valid and ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module hdc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r];

  // ********************************
  // storage
  // ********************************
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      if (push & ~pop) begin
        count_r <= count_r + (AW+1)'(1);
      end else if (pop & ~push) begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end

endmodule : hdc_fifo

// *** verif/hdc_dma_ctrl_chk.sv ***
/*
  checker of the dma request control ports.
  assumes bind onto hdc_dma_ctrl, one clock, rst active high.
*/
`timescale 1ns/10ps
module hdc_dma_ctrl_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [hdc_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [hdc_pkg::DATA_W-1:0] buf_data,
  input wire logic buf_valid,
  input wire logic buf_ready,
  input wire logic dma_req_pin,
  input wire logic dma_ack_pin,
  input wire logic count_end_pin,
  input wire logic refresh_event_in,
  input wire logic [hdc_pkg::DATA_W-1:0] host_data,
  input wire logic host_wide
);
  // ****
  // control shadow
  // ****
  logic [7:0] ctl_r;
  logic wr0;
  logic wr1;
  assign wr0 = reg_write && reg_addr == hdc_pkg::OFS_BUS_DMA_CONTROL;
  assign wr1 = reg_write && reg_addr == hdc_pkg::OFS_DMA_TERM_COUNT;
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl_r <= 8'h00;
    end else if (wr0) begin
      ctl_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ****
  // assertions
  // ****
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctrl_read_back: assert property ((wr0 ##1 reg_read && reg_addr == hdc_pkg::OFS_BUS_DMA_CONTROL)
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'hBF)) else $error("control read back wrong");
  a_count_read_back: assert property ((wr1 ##1 reg_read && reg_addr == hdc_pkg::OFS_DMA_TERM_COUNT)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("count read back wrong");
  a_wide_follows_reg: assert property (wr0 |=> host_wide == $past(reg_wdata[7]))
    else $error("width select not taken");
  a_wide_held_stable: assert property (!wr0 |=> $stable(host_wide))
    else $error("width select moved without write");
  a_narrow_upper_zero: assert property ($changed(host_data) && !host_wide |-> host_data[15:8] == 8'h00)
    else $error("upper byte used in narrow mode");
  a_word_needs_ack: assert property ($changed(host_data) |-> $past(dma_ack_pin))
    else $error("word moved without acknowledge");
  a_req_drops_ack: assert property ($rose(dma_ack_pin) && ctl_r[3:2] == 2'h0
    |-> ##[1:5] dma_req_pin == ctl_r[0]) else $error("request not released after acknowledge");
  c_cycle_burst: cover property (ctl_r[3:2] == 2'h3 && $rose(dma_ack_pin));
  c_wide_word: cover property (host_wide && $changed(host_data));
  c_low_req: cover property (ctl_r[0] && $rose(dma_ack_pin));
endmodule : hdc_dma_ctrl_chk

// *** verif/hdc_host_model.sv ***
/*
  host dma controller model: acks requests, drives external tc.
  assumes request polarity and tc polarity are told by the bench.
*/
`timescale 1ns/10ps
module hdc_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic dma_req_pin,
  input wire logic req_pol,
  input wire logic tc_pol,
  input wire logic [7:0] tc_n,
  input wire logic [3:0] dly,
  output logic dma_ack_pin,
  output logic count_end_pin
);
  logic [7:0] cnt;
  logic [4:0] w;
  logic act;
  assign act = dma_req_pin ^ req_pol;
  assign count_end_pin = tc_pol ^ (dma_ack_pin && tc_n != 8'h00 && cnt + 8'h01 == tc_n);
  always @(posedge clock) begin
    if (rst || tc_n == 8'h00) begin
      cnt <= 8'h00;
    end else if (dma_ack_pin && w == 5'h03) begin
      cnt <= cnt + 8'h01;
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      dma_ack_pin <= 1'b0;
      w <= 5'h00;
    end else if (dma_ack_pin) begin
      w <= w + 5'h01;
      if (w == 5'h03) begin
        dma_ack_pin <= 1'b0;
        w <= 5'h00;
      end
    end else if (w < {1'b0, dly} + 5'h04) begin
      w <= w + 5'h01;
    end else if (act) begin
      dma_ack_pin <= 1'b1;
      w <= 5'h00;
    end
  end
endmodule : hdc_host_model

// *** verif/test_hdc_dma_ctrl.sv ***
/*
  bench of the dma request control: registers, fifo fill, four modes.
  assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_hdc_dma_ctrl;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] buf_data = 16'h0000;
  logic [15:0] host_data;
  logic buf_valid = 1'b0;
  logic buf_ready, dma_req_pin, dma_ack_pin, count_end_pin, host_wide;
  logic refresh_event_in = 1'b1;
  logic ref_en = 1'b0;
  logic [5:0] rc = 6'h00;
  logic [7:0] ctl = 8'h00;
  logic [7:0] tc_n = 8'h00;
  logic [3:0] dly = 4'h0;
  logic [7:0] q;
  int mismatches = 0;
  int checks = 0;
  int n;
  logic [7:0] cc [4] = '{8'h20, 8'h87, 8'h2C, 8'h18};
  logic [7:0] ct [4] = '{8'h03, 8'h00, 8'h02, 8'h03};
  logic [7:0] cn [4] = '{8'h00, 8'h02, 8'h04, 8'h07};
  logic [15:0] cd [4] = '{16'h0002, 16'hA104, 16'h0008, 16'h000F};
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    rc <= rc + 6'h01;
    refresh_event_in <= !(ref_en && rc[5:3] == 3'h0);
  end
  hdc_dma_ctrl #(.STEP_CYCLES(2)) u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .buf_data(buf_data), .buf_valid(buf_valid), .buf_ready(buf_ready), .dma_req_pin(dma_req_pin),
    .dma_ack_pin(dma_ack_pin), .count_end_pin(count_end_pin), .refresh_event_in(refresh_event_in),
    .host_data(host_data), .host_wide(host_wide));
  hdc_host_model u_host (.clock(clock), .rst(rst), .dma_req_pin(dma_req_pin), .req_pol(ctl[0]),
    .tc_pol(ctl[1]), .tc_n(tc_n), .dly(dly), .dma_ack_pin(dma_ack_pin), .count_end_pin(count_end_pin));
  // ****
  // tasks
  // ****
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // write, then read the same register with no gap between the strobes
  task automatic wr_rd(input logic [1:0] a, input logic [7:0] w, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : wr_rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic run_case(input int i);
    int k;
    wr(2'h0, cc[i]);
    // model polarity flips at the edge where the request pin does
    @(posedge clock);
    ctl <= cc[i];
    tc_n <= cn[i];
    dly <= 4'(i * 2);
    wr_rd(2'h1, ct[i], q);
    `CHK("count back", ct[i], q)
    wr(2'h2, 8'h01);
    if (i == 3) begin
      rd(2'h2, q);
      `CHK("sync wait", 8'h21, q)
      ref_en <= 1'b1;
    end
    k = 0;
    q = 8'h00;
    while (q[1] !== 1'b1 && k < 3000) begin
      rd(2'h2, q);
      k++;
    end
    if (q[1] !== 1'b1) begin
      mismatches++;
      test_done();
    end
    ref_en <= 1'b0;
    rd(2'h3, q);
    `CHK("xfer count", cn[i] == 8'h00 ? ct[i] : cn[i], q)
    `CHK("host data", cd[i], host_data)
    `CHK("req idle", cc[i][0], dma_req_pin)
    wr(2'h2, 8'h02);
    // restarts the model's transfer tally
    tc_n <= 8'h00;
  endtask : run_case
  // ****
  // main sequence
  // ****
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(2'h0, q);
    `CHK("ctrl reset", 8'h00, q)
    rd(2'h1, q);
    `CHK("count reset", 8'h00, q)
    rd(2'h2, q);
    `CHK("run idle", 8'h10, q)
    `CHK("req reset", 1'b0, dma_req_pin)
    wr_rd(2'h0, 8'hFF, q);
    `CHK("ctrl back", 8'hBF, q)
    `CHK("wide on", 1'b1, host_wide)
    `CHK("req low pol", 1'b1, dma_req_pin)
    wr(2'h0, 8'h00);
    @(posedge clock);
    buf_valid <= 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge clock);
      q[0] = buf_ready;
      @(posedge clock);
      if (q[0] === 1'b1) begin
        n++;
        buf_data <= 16'hA100 + 16'(n);
      end
    end
    buf_valid <= 1'b0;
    `CHK("fifo fill", 16, n)
    for (int i = 0; i < 4; i++) run_case(i);
    `CHK("fifo drained", 1'b1, buf_ready)
    test_done();
  end
endmodule : test_hdc_dma_ctrl
bind hdc_dma_ctrl hdc_dma_ctrl_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .buf_data(buf_data), .buf_valid(buf_valid), .buf_ready(buf_ready), .dma_req_pin(dma_req_pin),
  .dma_ack_pin(dma_ack_pin), .count_end_pin(count_end_pin), .refresh_event_in(refresh_event_in),
  .host_data(host_data), .host_wide(host_wide));
